//--- rtl/serial_pkg.sv
/*
  Constants and carrier types for the asynchronous serial interface block.
  Assumes a single bus clock and a plain strobe register port.
*/
package serial_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_CTRL1 = 3'h3;
  localparam logic [2:0] ADDR_CTRL2 = 3'h4;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int ST_TXE = 7;
  localparam int ST_TC = 6;
  localparam int ST_RXR = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVR = 3;
  localparam int ST_NF = 2;
  localparam int ST_FE = 1;
  localparam int ST_PE = 0;
  localparam int C1_R8 = 7;
  localparam int C1_T8 = 6;
  localparam int C1_LPD = 5;
  localparam int C1_LEN9 = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_PEN = 2;
  localparam int C1_PODD = 1;
  localparam int C1_PIE = 0;
  localparam int C2_TIE = 7;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_RIE = 5;
  localparam int C2_IDLE_IRQ_EN = 4;
  localparam int C2_TE = 3;
  localparam int C2_RE = 2;
  localparam int C2_MUTE = 1;
  localparam int C2_SBK = 0;

  // --------------------------------------------------------------
  // Reset values and timing
  // --------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'hC0;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h0056;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  // Register port request carrier
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Transmitter kinds of frame
  typedef enum logic [1:0] {
    FR_DATA,
    FR_IDLE,
    FR_BREAK
  } frame_kind_t;

endpackage

//--- rtl/serial_uart.sv
/*
  Asynchronous serial interface: status, control, data registers, a
  transmitter and a 16x oversampling receiver.
  Assumes i_rx comes from a pin; register port is on the same clock.
*/
// Summary of operation
// - tx_complete set after data frame, cleared status-write
// - no tx_complete after idle or break frames
// - rx_word_ready set on transfer, cleared status-read
// - idle flag rearmed only after new word ready
// - overrun keeps old word, interrupts with enable
// - noise flag never set, since each new start clears the noise bit; no own interrupt
// - framing flag; overrun masks framing on same word
// - parity error flag with its own interrupt enable
// - ninth bit captured and sent in nine-bit mode
// - low power disable stops after current frame
// - eight or nine data bits per frame
// - wake by idle line or address mark
// - parity in top data bit, checked on receive
// - even or odd parity, latched per frame
// - interrupt on empty or complete with enables
// - receive interrupt on ready or overrun
// - one idle frame delay on enable; toggle sends preamble
// - receiver enable starts start-bit search
// - mute mode until wake sequence clears bit
// - mute writes ignored while word ready, mark mode
// - send break while set; clearing the bit queues one more
// - empty flag set on load, shifter waits clear
`timescale 1ns/1ps
`default_nettype none
module serial_uart #(
  parameter logic [15:0] DIV_DEFAULT = serial_pkg::BAUD_DIV_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire serial_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  input wire logic i_rx,
  output logic o_tx,
  output logic o_irq
);
  import serial_pkg::*;

  // --------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------
  logic [7:0] status_q, ctrl1_q, ctrl2_q, txh_q, rxh_q;
  logic [15:0] baud_q, bcnt_q;
  logic status_seen_q, tick;
  logic [1:0] rx_sync_q;
  logic tx_busy_q, rx_busy_q, te_q, sbk_q, brk_pend_q, pre_pend_q;
  logic [3:0] tx_os_q, tx_bit_q, rx_os_q, rx_bit_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_len_q;
  frame_kind_t tx_kind_q;
  logic [8:0] rx_sh_q;
  logic rx_noise_q, rx_par_q, rx_len9_q, rx_pen_q, rx_podd_q;
  logic [3:0] idle_cnt_q, idle_os_q;
  logic idle_arm_q;
  logic [7:0] rdata_q;
  logic irq_q, tx_q, rx_s;
  logic st_acc, wr_data, rd_data, rx_done, rx_stop_ok, rx_perr, rx_addr_mark;

  // Parity of a word under the selected width
  function automatic logic par_of(input logic [8:0] w, input logic len9, input logic odd);
    par_of = (len9 ? ^w[7:0] : ^w[6:0]) ^ odd;
  endfunction

  assign rx_s = rx_sync_q[1];
  assign st_acc = (i_req.rd || i_req.wr) && (i_req.addr == ADDR_STATUS);
  assign wr_data = i_req.wr && (i_req.addr == ADDR_DATA) && status_seen_q;
  assign rd_data = i_req.rd && (i_req.addr == ADDR_DATA) && status_seen_q;

  // --------------------------------------------------------------
  // Pin synchroniser and oversampling tick
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_sync_q <= 2'b11;
    end else if (i_ce) begin
      rx_sync_q <= {rx_sync_q[0], i_rx};
    end
  end

  // Prescaler halts under low-power disable once both shifters idle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bcnt_q <= 16'h0000;
    end else if (i_ce) begin
      if (ctrl1_q[C1_LPD] && !tx_busy_q && !rx_busy_q) begin
        bcnt_q <= 16'h0000;
      end else if (bcnt_q >= baud_q) begin
        bcnt_q <= 16'h0000;
      end else begin
        bcnt_q <= bcnt_q + 16'h0001;
      end
    end
  end
  assign tick = (bcnt_q >= baud_q) && !(ctrl1_q[C1_LPD] && !tx_busy_q && !rx_busy_q);

  // --------------------------------------------------------------
  // Register writes and clear sequence tracking
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_seen_q <= 1'b0;
    end else if (i_ce) begin
      if (st_acc) begin
        status_seen_q <= 1'b1;
      end else if (i_req.addr == ADDR_DATA && (i_req.rd || i_req.wr)) begin
        status_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl1_q <= ZERO8;
      ctrl2_q <= ZERO8;
      baud_q <= DIV_DEFAULT;
      txh_q <= ZERO8;
    end else if (i_ce) begin
      if (i_req.wr && i_req.addr == ADDR_CTRL1) begin
        ctrl1_q[6:0] <= i_req.wdata[6:0];
      end
      if (i_req.wr && i_req.addr == ADDR_CTRL2) begin
        ctrl2_q[7:2] <= i_req.wdata[7:2];
        ctrl2_q[C2_SBK] <= i_req.wdata[C2_SBK];
        if (!(ctrl1_q[C1_WAKE] && status_q[ST_RXR])) begin
          ctrl2_q[C2_MUTE] <= i_req.wdata[C2_MUTE];
        end
      end else if (rx_done && ctrl2_q[C2_MUTE] && ctrl1_q[C1_WAKE] && rx_addr_mark) begin
        ctrl2_q[C2_MUTE] <= 1'b0; // Address mark wakes receiver
      end else if (ctrl2_q[C2_MUTE] && !ctrl1_q[C1_WAKE] && idle_cnt_q == BITS_9 + 4'h1) begin
        ctrl2_q[C2_MUTE] <= 1'b0; // Idle line wakes receiver
      end
      if (rx_done && !ctrl2_q[C2_MUTE]) begin
        ctrl1_q[C1_R8] <= rx_sh_q[8];
      end
      if (i_req.wr && i_req.addr == ADDR_BAUD) begin
        baud_q <= {8'h00, i_req.wdata};
      end
      if (i_req.wr && i_req.addr == ADDR_DATA) begin
        txh_q <= i_req.wdata;
      end
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= ZERO8;
    end else if (i_ce) begin
      rdata_q <= ZERO8;
      if (i_req.rd) begin
        case (i_req.addr)
          ADDR_STATUS: rdata_q <= status_q;
          ADDR_DATA: rdata_q <= rxh_q;
          ADDR_BAUD: rdata_q <= baud_q[7:0];
          ADDR_CTRL1: rdata_q <= ctrl1_q;
          ADDR_CTRL2: rdata_q <= ctrl2_q;
          default: rdata_q <= ZERO8;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------
  logic tx_load, tx_end;
  assign tx_end = tx_busy_q && tick && tx_os_q == OVERSAMPLE_LAST && tx_bit_q == tx_len_q;
  assign tx_load = te_q && !tx_busy_q && !ctrl1_q[C1_LPD]
    && (pre_pend_q || brk_pend_q || sbk_q || !status_q[ST_TXE]);

  // Enable edges: a fresh enable sends a preamble, which gives the idle frame delay
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      te_q <= 1'b0;
      sbk_q <= 1'b0;
      brk_pend_q <= 1'b0;
      pre_pend_q <= 1'b0;
    end else if (i_ce) begin
      te_q <= ctrl2_q[C2_TE];
      sbk_q <= ctrl2_q[C2_SBK];
      if (ctrl2_q[C2_TE] && !te_q) begin
        pre_pend_q <= 1'b1;
      end else if (tx_load) begin
        pre_pend_q <= 1'b0; // The pending preamble is the frame just loaded
      end
      if (sbk_q && !ctrl2_q[C2_SBK]) begin
        brk_pend_q <= 1'b1;
      end else if (tx_load && !pre_pend_q && !sbk_q) begin
        brk_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_busy_q <= 1'b0;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 11'h7FF;
      tx_len_q <= 4'h0;
      tx_kind_q <= FR_DATA;
      tx_q <= 1'b1;
    end else if (i_ce) begin
      if (tx_load) begin
        tx_busy_q <= 1'b1;
        tx_os_q <= 4'h0;
        tx_bit_q <= 4'h0;
        tx_len_q <= ctrl1_q[C1_LEN9] ? BITS_9 + 4'h1 : BITS_8 + 4'h1;
        if (pre_pend_q) begin
          tx_kind_q <= FR_IDLE;
          tx_sh_q <= 11'h7FF;
        end else if (sbk_q || brk_pend_q) begin
          tx_kind_q <= FR_BREAK;
          tx_sh_q <= 11'h000;
        end else begin
          tx_kind_q <= FR_DATA;
          // Start, data, ninth bit or parity, stop
          if (ctrl1_q[C1_LEN9]) begin
            tx_sh_q <= {1'b1, ctrl1_q[C1_PEN] ? par_of({1'b0, txh_q}, 1'b1, ctrl1_q[C1_PODD])
              : ctrl1_q[C1_T8], txh_q, 1'b0};
          end else begin
            tx_sh_q <= {2'b11, ctrl1_q[C1_PEN] ? par_of({1'b0, txh_q}, 1'b0, ctrl1_q[C1_PODD])
              : txh_q[7], txh_q[6:0], 1'b0};
          end
        end
      end else if (tx_busy_q && tick) begin
        tx_os_q <= tx_os_q + 4'h1;
        if (tx_os_q == OVERSAMPLE_LAST) begin
          tx_bit_q <= tx_bit_q + 4'h1;
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
          if (tx_end) begin
            tx_busy_q <= 1'b0;
          end
        end
      end
      // Break keeps the line low through its stop slot; outputs idle when disabled
      tx_q <= !te_q || ctrl1_q[C1_LPD] && !tx_busy_q ? 1'b1
        : (tx_busy_q ? (tx_kind_q == FR_BREAK ? 1'b0 : tx_sh_q[0]) : 1'b1);
    end
  end

  // --------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------
  logic rx_sample;
  assign rx_sample = rx_busy_q && tick && rx_os_q == SAMPLE_MID;
  assign rx_done = rx_sample && rx_bit_q == (rx_len9_q ? BITS_9 + 4'h1 : BITS_8 + 4'h1);
  assign rx_stop_ok = rx_s;
  assign rx_addr_mark = rx_len9_q ? rx_sh_q[8] : rx_sh_q[7];
  assign rx_perr = rx_pen_q && (par_of(rx_sh_q, rx_len9_q, rx_podd_q)
    != (rx_len9_q ? rx_sh_q[8] : rx_sh_q[7]));

  // Start search only while enabled; frame settings latched at start
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_busy_q <= 1'b0;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_noise_q <= 1'b0;
      rx_len9_q <= 1'b0;
      rx_pen_q <= 1'b0;
      rx_podd_q <= 1'b0;
    end else if (i_ce) begin
      if (!rx_busy_q && ctrl2_q[C2_RE] && !ctrl1_q[C1_LPD] && !rx_s) begin
        rx_busy_q <= 1'b1;
        rx_os_q <= 4'h0;
        rx_bit_q <= 4'h0;
        rx_noise_q <= 1'b0;
        rx_len9_q <= ctrl1_q[C1_LEN9];
        rx_pen_q <= ctrl1_q[C1_PEN];
        rx_podd_q <= ctrl1_q[C1_PODD];
      end else if (rx_busy_q && tick) begin
        rx_os_q <= rx_os_q + 4'h1;
        if (rx_sample) begin
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rx_s) begin
            rx_busy_q <= 1'b0; // False start
            rx_noise_q <= 1'b1;
          end else if (rx_done) begin
            rx_busy_q <= 1'b0;
          end else if (rx_bit_q != 4'h0) begin
            rx_sh_q <= rx_len9_q ? {rx_s, rx_sh_q[8:1]} : {1'b0, rx_s, rx_sh_q[7:1]};
          end
        end
      end
    end
  end

  // Idle line counter: ten high bit times in either frame width, 16 ticks each
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_cnt_q <= 4'h0;
      idle_os_q <= 4'h0;
    end else if (i_ce) begin
      if (rx_busy_q || !rx_s || !ctrl2_q[C2_RE]) begin
        idle_cnt_q <= 4'h0;
        idle_os_q <= 4'h0;
      end else if (tick && idle_cnt_q != BITS_9 + 4'h1) begin
        idle_os_q <= idle_os_q + 4'h1;
        if (idle_os_q == OVERSAMPLE_LAST) begin
          idle_cnt_q <= idle_cnt_q + 4'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Status flags: set wins over the software clear
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= STATUS_RESET;
      rxh_q <= ZERO8;
      idle_arm_q <= 1'b0;
    end else if (i_ce) begin
      if (wr_data) begin
        status_q[ST_TXE] <= 1'b0;
        status_q[ST_TC] <= 1'b0;
      end
      if (tx_load && !pre_pend_q && !sbk_q && !brk_pend_q) begin
        status_q[ST_TXE] <= 1'b1; // Holding register moved to shifter
      end
      if (tx_end && tx_kind_q == FR_DATA) begin
        status_q[ST_TC] <= 1'b1; // Only data frames complete
      end
      if (rd_data) begin
        status_q[5:0] <= 6'h00;
      end
      if (rx_done && !ctrl2_q[C2_MUTE]) begin
        if (status_q[ST_RXR] && !rd_data) begin
          status_q[ST_OVR] <= 1'b1; // Old word kept, framing hidden
        end else begin
          rxh_q <= rx_sh_q[7:0];
          status_q[ST_RXR] <= 1'b1;
          idle_arm_q <= 1'b1;
          status_q[ST_NF] <= rx_noise_q;
          status_q[ST_FE] <= !rx_stop_ok;
          status_q[ST_PE] <= rx_perr;
        end
      end else if (idle_arm_q && idle_cnt_q == BITS_9 + 4'h1 && !ctrl2_q[C2_MUTE]) begin
        status_q[ST_IDLE] <= 1'b1;
        idle_arm_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Interrupt request and outputs
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_q <= 1'b0;
    end else if (i_ce) begin
      irq_q <= (status_q[ST_TXE] && ctrl2_q[C2_TIE])
        || (status_q[ST_TC] && ctrl2_q[C2_TX_DONE_IRQ_EN])
        || ((status_q[ST_RXR] || status_q[ST_OVR]) && ctrl2_q[C2_RIE])
        || (status_q[ST_IDLE] && ctrl2_q[C2_IDLE_IRQ_EN])
        || (status_q[ST_PE] && ctrl1_q[C1_PIE]);
    end
  end

  assign o_rdata = rdata_q;
  assign o_tx = tx_q;
  assign o_irq = irq_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  property p_tc_only_data;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(status_q[ST_TC]) |-> $past(tx_kind_q) == FR_DATA;
  endproperty
  a_tc_only_data: assert property (p_tc_only_data) else $error("tc after non-data");

  property p_irq_rx;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && status_q[ST_RXR] && ctrl2_q[C2_RIE] |=> irq_q;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx irq missing");

  property p_irq_txe;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && status_q[ST_TXE] && ctrl2_q[C2_TIE] |=> irq_q;
  endproperty
  a_irq_txe: assert property (p_irq_txe) else $error("tx irq missing");

  property p_ovr_keeps;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(status_q[ST_OVR]) |-> $stable(rxh_q);
  endproperty
  a_ovr_keeps: assert property (p_ovr_keeps) else $error("overrun lost word");

  property p_no_load_full;
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(tx_busy_q) && $past(tx_kind_q) == FR_DATA && tx_kind_q == FR_DATA
      |-> !$past(status_q[ST_TXE]);
  endproperty
  a_no_load_full: assert property (p_no_load_full) else $error("loaded empty data");

  property p_break_low;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ce && tx_busy_q && tx_kind_q == FR_BREAK && te_q |=> !o_tx;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break not low");

  c_rx_word: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(status_q[ST_RXR]));
  c_tx_done: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(status_q[ST_TC]));
  c_overrun: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(status_q[ST_OVR]));
endmodule
`default_nettype wire

//--- test/serial_peer.sv
/*
  Remote serial peer: sends frames onto the block's receive pin and
  captures each frame the block transmits that starts over half a bit time after the last one ended, start bit first.
  Assumes one bus clock and a fixed bit time in clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BIT_CLKS = 64
) (
  input wire logic i_clk,
  input wire logic i_line_in,
  input wire logic i_len9,
  output logic o_line_out
);
  logic [10:0] frame_q;
  int frame_cnt;

  // ------------------------------------------------------------
  // Line driver
  // ------------------------------------------------------------
  initial begin
    o_line_out = 1'b1;
    frame_cnt = 0;
    frame_q = '0;
  end

  // Start bit, data LSB first, chosen stop level, then idle high
  task automatic send_word(input logic [8:0] word, input int nbits, input logic stop_bit);
    @(posedge i_clk);
    o_line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int k = 0; k < nbits; k++) begin
      o_line_out <= word[k];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_line_out <= stop_bit;
    repeat (BIT_CLKS) @(posedge i_clk);
    o_line_out <= 1'b1;
  endtask

  // ------------------------------------------------------------
  // Frame monitor: samples mid-bit, waits for the line to go high
  // ------------------------------------------------------------
  always begin
    @(negedge i_line_in);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    frame_q = '0;
    for (int k = 0; k < (i_len9 ? 11 : 10); k++) begin
      frame_q[k] = i_line_in;
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    frame_cnt++;
    wait (i_line_in === 1'b1);
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
/*
  Self-checking bench for the serial block: register tasks on the
  strobe port and sequences of calls against the remote peer model.
  Assumes the design package and a 5 ns clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import serial_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic len9 = 1'b0;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic rx;
  logic tx;
  logic irq;
  logic [7:0] v;
  int err_total = 0;
  int checks_done = 0;

  // ------------------------------------------------------------
  // Clock, design and peer
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;

  serial_uart u_dut (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1), .i_req(req),
    .o_rdata(rdata), .i_rx(rx), .o_tx(tx), .o_irq(irq));
  serial_peer #(.BIT_CLKS(64)) u_peer (.i_clk(clk), .i_line_in(tx), .i_len9(len9),
    .o_line_out(rx));

  // ------------------------------------------------------------
  // Register port tasks
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    rd_reg(a, d);
    `CHK(d & m, e)
  endtask

  // Status access then data write queues one transmit byte
  task automatic send_tx(input logic [7:0] d);
    rd_reg(ADDR_STATUS, v);
    wr_reg(ADDR_DATA, d);
  endtask

  task automatic wait_frame();
    int c;
    c = u_peer.frame_cnt;
    for (int k = 0; k < 3000 && u_peer.frame_cnt == c; k++) @(posedge clk);
  endtask

  // Peer word, then idle time for the idle detector
  task automatic rx_word(input logic [8:0] w, input int n, input logic stp);
    u_peer.send_word(w, n, stp);
    repeat (800) @(posedge clk);
  endtask

  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    test_done();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    chk_reg(ADDR_STATUS, 8'hC0, 8'hFF);
    chk_reg(ADDR_CTRL2, 8'h00, 8'hFF);
    chk_reg(ADDR_CTRL1, 8'h00, 8'h7F);
    chk_reg(3'h7, 8'h00, 8'hFF);
    `CHK(irq, 1'b0)
    wr_reg(ADDR_BAUD, 8'h03);
    // Receive path with its interrupt
    wr_reg(ADDR_CTRL2, 8'h24);
    rx_word(9'h05A, 8, 1'b1);
    chk_reg(ADDR_STATUS, 8'hF0, 8'hFF);
    `CHK(irq, 1'b1)
    chk_reg(ADDR_DATA, 8'h5A, 8'hFF);
    chk_reg(ADDR_STATUS, 8'hC0, 8'hFF);
    `CHK(irq, 1'b0)
    repeat (1500) @(posedge clk);
    chk_reg(ADDR_STATUS, 8'h00, 8'h10);
    // Overrun, with a framing fault on the lost word
    u_peer.send_word(9'h011, 8, 1'b1);
    rx_word(9'h022, 8, 1'b0);
    wr_reg(ADDR_CTRL1, 8'h08);
    wr_reg(ADDR_CTRL2, 8'h26);
    chk_reg(ADDR_CTRL2, 8'h24, 8'hFF);
    wr_reg(ADDR_CTRL1, 8'h00);
    chk_reg(ADDR_STATUS, 8'h28, 8'h2B);
    chk_reg(ADDR_DATA, 8'h11, 8'hFF);
    chk_reg(ADDR_STATUS, 8'h00, 8'h2B);
    // Framing fault alone, then a parity fault
    rx_word(9'h033, 8, 1'b0);
    chk_reg(ADDR_STATUS, 8'h22, 8'h2B);
    chk_reg(ADDR_DATA, 8'h33, 8'hFF);
    wr_reg(ADDR_CTRL1, 8'h04);
    rx_word(9'h001, 8, 1'b1);
    chk_reg(ADDR_STATUS, 8'h21, 8'h2B);
    chk_reg(ADDR_DATA, 8'h01, 8'h7F);
    chk_reg(ADDR_STATUS, 8'h00, 8'h2F);
    // Transmit path with the complete interrupt
    wr_reg(ADDR_CTRL1, 8'h00);
    wr_reg(ADDR_CTRL2, 8'h4C);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    send_tx(8'hA5);
    chk_reg(ADDR_STATUS, 8'h00, 8'h40);
    wait_frame();
    `CHK(u_peer.frame_q, {2'b01, 8'hA5, 1'b0})
    repeat (20) @(posedge clk);
    chk_reg(ADDR_STATUS, 8'hC0, 8'hC0);
    `CHK(irq, 1'b1)
    // Even and odd parity in the top data position
    for (int ps = 0; ps < 2; ps++) begin
      wr_reg(ADDR_CTRL1, ps[0] ? 8'h06 : 8'h04);
      send_tx(8'h35);
      wait_frame();
      `CHK(u_peer.frame_q, {2'b01, ps[0] ? 8'hB5 : 8'h35, 1'b0})
    end
    // Nine-bit words both ways
    wr_reg(ADDR_CTRL1, 8'h50);
    len9 = 1'b1;
    send_tx(8'h3C);
    wait_frame();
    `CHK(u_peer.frame_q, {2'b11, 8'h3C, 1'b0})
    rx_word(9'h15A, 9, 1'b1);
    chk_reg(ADDR_CTRL1, 8'h80, 8'h80);
    chk_reg(ADDR_DATA, 8'h5A, 8'hFF);
    wr_reg(ADDR_CTRL1, 8'h00);
    len9 = 1'b0;
    // Break pulse, then a queued data word
    wr_reg(ADDR_CTRL2, 8'h4D);
    wr_reg(ADDR_CTRL2, 8'h4C);
    send_tx(8'h0F);
    wait_frame();
    `CHK(u_peer.frame_q, 11'h000)
    repeat (100) @(posedge clk);
    chk_reg(ADDR_STATUS, 8'h00, 8'h40);
    wait_frame();
    `CHK(u_peer.frame_q, {2'b01, 8'h0F, 1'b0})
    repeat (20) @(posedge clk);
    chk_reg(ADDR_STATUS, 8'h40, 8'h40);
    test_done();
  end
endmodule
`default_nettype wire
